// ### hdl/fhl_pkg.sv
/*
  constants, types and the hash fold shared by the hash and learn block.
  assumes a single core clock and that every user sees this package first.
*/
// Overview of operation
// RULE1 - hash xors key slices, top slice zero-extended
// RULE2 - ipv4 key vrf over address, ten-bit hash
// RULE3 - ipv6 key vrf over address, thirteen slices
// RULE4 - mpls key vrf, label, source port, folded
// RULE5 - l3 hashes are routing table read index
// RULE6 - l2 key gid with mac, ten-bit hash
// RULE7 - new entry records source port, mac, gid
// RULE8 - destination hit yields stored destination port
// RULE9 - aging removes idle non-static entries only
// RULE10 - known mac on other port means move
// RULE11 - learning and aging on after reset, switchable
// RULE12 - per-port learn enable cleared suppresses learning
// RULE13 - destination miss drops or floods per port
// RULE14 - learned entry status comes from configuration
// RULE15 - one destination and one source lookup per cycle
// RULE16 - every table write hits both replicas
// RULE17 - collision table shared by both lookups
// RULE18 - source hit needs valid replica or collision
// RULE19 - source hit compares port with stored port
// RULE20 - decisions: learn, port move, hit update
// RULE21 - l2 key split in six slices
// RULE22 - four buckets of 1024 read in parallel
// RULE23 - bucket index bucket:hash, collision index plus 4096
// RULE24 - status holds valid, static and hit
// RULE25 - hash combinational from registered key
// RULE26 - decision strobe, code, key, port; gated
package fhl_pkg;
  // =========================================================
  // widths and table sizes
  localparam int HASH_W = 10;
  localparam int NBKT = 4;
  localparam int BKT_W = 2;
  localparam int HIDX_W = 12;
  localparam int HASH_N = 4096;
  localparam int COL_N = 16;
  localparam int COL_W = 4;
  localparam int DIDX_W = 13;
  localparam int DEST_N = 4112;
  localparam int GID_W = 12;
  localparam int MAC_W = 48;
  localparam int L2K_W = 60;
  localparam int PORT_W = 4;
  localparam int NPORT = 16;
  localparam int VRF_W = 2;
  localparam int LBL_W = 20;
  localparam int FOLD_W = 130;
  localparam int FOLD_N = 13;
  localparam int ADDR_W = 8;
  localparam int AGE_CYC_DEF = 100000000;
  // =========================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PLEARN = 8'h04;
  localparam logic [7:0] OFS_PDROP = 8'h08;
  localparam logic [7:0] OFS_TWLO = 8'h0c;
  localparam logic [7:0] OFS_TWHI = 8'h10;
  localparam logic [7:0] OFS_TWDAT = 8'h14;
  localparam logic [7:0] OFS_TWCMD = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1c;
  // =========================================================
  // field positions and reset values
  localparam int CTRL_LEARN_BIT = 0;
  localparam int CTRL_AGE_BIT = 1;
  localparam int CTRL_INIT_LSB = 2;
  localparam int TWHI_GID_LSB = 16;
  localparam int TWDAT_ST_LSB = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0017;
  localparam logic [31:0] PLEARN_RST = 32'h0000_ffff;
  localparam logic [31:0] PDROP_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // =========================================================
  // types
  typedef enum logic [1:0] {FHL_DEC_LEARN, FHL_DEC_MOVE, FHL_DEC_HIT} fhl_dec_t;
  typedef struct packed {logic hit; logic stat; logic valid;} fhl_stat_t;
  typedef struct packed {
    logic valid;
    logic [GID_W-1:0] gid;
    logic [MAC_W-1:0] mac;
    logic [PORT_W-1:0] port;
  } fhl_l2_req_t;
  typedef struct packed {
    logic valid;
    logic hit;
    logic drop;
    logic flood;
    logic [PORT_W-1:0] port;
    logic [DIDX_W-1:0] idx;
  } fhl_da_res_t;
  typedef struct packed {
    logic valid;
    fhl_dec_t code;
    logic [GID_W-1:0] gid;
    logic [MAC_W-1:0] mac;
    logic [PORT_W-1:0] port;
    logic [DIDX_W-1:0] idx;
    fhl_stat_t status;
  } fhl_sa_dec_t;
  typedef struct packed {
    logic valid;
    logic [VRF_W-1:0] vrf;
    logic [31:0] ip4;
    logic [127:0] ip6;
    logic [LBL_W-1:0] label;
    logic [PORT_W-1:0] port;
  } fhl_l3_req_t;
  typedef struct packed {
    logic valid;
    logic [HASH_W-1:0] v4;
    logic [HASH_W-1:0] v6;
    logic [HASH_W-1:0] mpls;
  } fhl_l3_hash_t;
  // =========================================================
  // xor fold of a zero-padded key into one hash slice
  function automatic logic [HASH_W-1:0] fhl_fold(input logic [FOLD_W-1:0] key);
    logic [HASH_W-1:0] h;
    h = '0;
    for (int i = 0; i < FOLD_N; i++) begin
      h = h ^ key[i*HASH_W +: HASH_W]; // RULE1
    end
    return h;
  endfunction
endpackage

// ### hdl/fhl_top.sv
/*
  hash index generation for l2, ipv4, ipv6 and mpls lookups, the l2 forwarding
  base with bucket and collision tables, the source lookup learn decision and
  a hardware aging sweep; registers over axi4-lite.
  assumes lookup requests synchronous to ref_clk_i and a bus master that
  keeps one read and one write outstanding at most.
*/
`timescale 1ns/100ps
module fhl_top #(
  parameter int AGE_CYC = fhl_pkg::AGE_CYC_DEF
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [fhl_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  // axi4-lite write response
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // axi4-lite read
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [fhl_pkg::ADDR_W-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // lookup requests from the ingress pipeline
  input wire fhl_pkg::fhl_l2_req_t da_req_i,
  input wire fhl_pkg::fhl_l2_req_t sa_req_i,
  input wire fhl_pkg::fhl_l3_req_t l3_req_i,
  // lookup results
  output fhl_pkg::fhl_da_res_t da_res_o,
  output fhl_pkg::fhl_sa_dec_t sa_dec_o,
  output fhl_pkg::fhl_l3_hash_t l3_hash_o
);
  import fhl_pkg::*;

  // =========================================================
  // declarations
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg; // bus handshake flops
  logic [1:0] bresp_reg, rresp_reg; // bus responses
  logic [31:0] rdata_reg; // read data
  logic [ADDR_W-1:0] aw_addr_reg; // captured write address
  logic [31:0] w_data_reg; // captured write data
  logic [3:0] w_strb_reg; // captured byte enables
  logic wr_fire; // both halves held, response free
  logic [31:0] ctrl_reg, plearn_reg, pdrop_reg; // control registers
  logic [31:0] twlo_reg, twhi_reg, twdat_reg; // table write staging
  logic [15:0] dec_cnt_reg; // decisions emitted
  logic tw_go; // table write strobe
  logic [DIDX_W-1:0] tw_idx; // table write index
  logic [L2K_W-1:0] tw_key; // table write key
  logic [31:0] rd_data; // read mux
  logic rd_ok; // read address mapped
  fhl_l2_req_t req_reg [2]; // registered keys, 0 dest 1 source
  fhl_l3_req_t l3_reg; // registered l3 key
  logic [HASH_W-1:0] lk_hash [2]; // l2 hash per side
  logic lk_hit [2]; // lookup hit per side
  logic [DIDX_W-1:0] lk_idx [2]; // destination table index per side
  logic [PORT_W-1:0] lk_port [2]; // stored port per side
  logic [L2K_W-1:0] key_mem [2][HASH_N]; // bucket keys, dest and source copies
  logic [PORT_W-1:0] port_mem [2][DEST_N]; // destination table and replica
  logic shd_mem [2][DEST_N]; // status shadow valid and replica
  logic [L2K_W-1:0] col_key [COL_N]; // shared collision keys
  fhl_stat_t st_mem [DEST_N]; // status table
  logic [31:0] age_cnt_reg; // aging period counter
  logic sweep_reg; // aging sweep running
  logic [DIDX_W-1:0] sweep_ix_reg; // aging sweep index
  fhl_da_res_t da_res_reg; // dest result flop
  fhl_sa_dec_t sa_dec_reg; // source decision flop
  fhl_l3_hash_t l3_hash_reg; // l3 hash flop
  logic [25:0] mk; // mpls key view, checking only

  // byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  // =========================================================
  // axi4-lite write channel
  assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;

  // address and data taken in either order, answer after both
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else begin
      if (awready_reg && s_axi_awvalid_i) begin // address taken
        awready_reg <= 1'b0;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (wready_reg && s_axi_wvalid_i) begin // data taken
        wready_reg <= 1'b0;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (wr_fire) begin // respond
        bvalid_reg <= 1'b1;
        bresp_reg <= (aw_addr_reg[ADDR_W-1:2] <= OFS_TWCMD[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready_i) begin // response accepted, reopen
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // software registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= CTRL_RST; // RULE11
      plearn_reg <= PLEARN_RST;
      pdrop_reg <= PDROP_RST;
      twlo_reg <= '0;
      twhi_reg <= '0;
      twdat_reg <= '0;
    end else if (wr_fire) begin
      case (aw_addr_reg)
        OFS_CTRL: ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & 32'h0000_001f;
        OFS_PLEARN: plearn_reg <= merge(plearn_reg, w_data_reg, w_strb_reg) & 32'h0000_ffff;
        OFS_PDROP: pdrop_reg <= merge(pdrop_reg, w_data_reg, w_strb_reg) & 32'h0000_ffff;
        OFS_TWLO: twlo_reg <= merge(twlo_reg, w_data_reg, w_strb_reg);
        OFS_TWHI: twhi_reg <= merge(twhi_reg, w_data_reg, w_strb_reg) & 32'h0fff_ffff;
        OFS_TWDAT: twdat_reg <= merge(twdat_reg, w_data_reg, w_strb_reg) & 32'h0000_007f;
        default: begin
          // command and unmapped offsets store nothing
        end
      endcase
    end
  end

  // table write command decode
  assign tw_idx = w_data_reg[DIDX_W-1:0];
  assign tw_go = wr_fire && (aw_addr_reg == OFS_TWCMD) && (tw_idx < DIDX_W'(DEST_N));
  assign tw_key = {twhi_reg[TWHI_GID_LSB +: GID_W], twhi_reg[15:0], twlo_reg};

  // =========================================================
  // axi4-lite read channel
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr_i)
      OFS_CTRL: rd_data = ctrl_reg;
      OFS_PLEARN: rd_data = plearn_reg;
      OFS_PDROP: rd_data = pdrop_reg;
      OFS_TWLO: rd_data = twlo_reg;
      OFS_TWHI: rd_data = twhi_reg;
      OFS_TWDAT: rd_data = twdat_reg;
      OFS_TWCMD: rd_data = '0;
      OFS_STAT: rd_data = {dec_cnt_reg, 15'h0000, sweep_reg};
      default: begin // unmapped reads zero with error
        rd_data = '0;
        rd_ok = 1'b0;
      end
    endcase
  end

  // one read at a time, answered the cycle after the address
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (arready_reg && s_axi_arvalid_i) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_data;
      rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // =========================================================
  // key registers, one of each lookup kind per cycle
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_reg[0] <= '0;
      req_reg[1] <= '0;
      l3_reg <= '0;
    end else begin
      req_reg[0] <= da_req_i; // RULE15
      req_reg[1] <= sa_req_i; // RULE15
      l3_reg <= l3_req_i;
    end
  end

  // =========================================================
  // l2 lookup, dest side 0 and source side 1
  for (genvar s = 0; s < 2; s++) begin : g_side
    always_comb begin
      lk_hash[s] = fhl_fold({70'h0, req_reg[s].gid, req_reg[s].mac}); // RULE6 RULE21 RULE25
      lk_hit[s] = 1'b0;
      lk_idx[s] = '0;
      for (int c = COL_N - 1; c >= 0; c--) begin // shared collision copy, first match wins
        if (col_key[c] == {req_reg[s].gid, req_reg[s].mac} && st_mem[HASH_N + c].valid) begin // RULE17 RULE18
          lk_hit[s] = 1'b1;
          lk_idx[s] = DIDX_W'(HASH_N + c); // RULE23
        end
      end
      for (int b = NBKT - 1; b >= 0; b--) begin // four buckets in parallel, bucket beats collision
        if (key_mem[s][{BKT_W'(b), lk_hash[s]}] == {req_reg[s].gid, req_reg[s].mac} &&
            shd_mem[s][{1'b0, BKT_W'(b), lk_hash[s]}]) begin // RULE22 RULE18
          lk_hit[s] = 1'b1;
          lk_idx[s] = {1'b0, BKT_W'(b), lk_hash[s]}; // RULE23
        end
      end
      lk_port[s] = port_mem[s][lk_idx[s]]; // RULE19
    end
  end

  // =========================================================
  // table contents, both replicas written together
  always_ff @(posedge ref_clk_i) begin
    if (tw_go) begin
      for (int s = 0; s < 2; s++) begin
        port_mem[s][tw_idx] <= twdat_reg[PORT_W-1:0]; // RULE16
        if (tw_idx < DIDX_W'(HASH_N)) begin
          key_mem[s][tw_idx[HIDX_W-1:0]] <= tw_key; // RULE16
        end
      end
      if (tw_idx >= DIDX_W'(HASH_N)) begin
        col_key[tw_idx[COL_W-1:0]] <= tw_key;
      end
    end
  end

  // status table and shadows: aging, hit marking, software write last
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < DEST_N; i++) begin
        st_mem[i] <= '0;
        shd_mem[0][i] <= 1'b0;
        shd_mem[1][i] <= 1'b0;
      end
    end else begin
      if (sweep_reg && st_mem[sweep_ix_reg].valid && !st_mem[sweep_ix_reg].stat) begin // RULE9
        if (st_mem[sweep_ix_reg].hit) begin
          st_mem[sweep_ix_reg].hit <= 1'b0; // referenced, give another period
        end else begin
          st_mem[sweep_ix_reg].valid <= 1'b0; // idle, remove
          shd_mem[0][sweep_ix_reg] <= 1'b0;
          shd_mem[1][sweep_ix_reg] <= 1'b0;
        end
      end
      for (int s = 0; s < 2; s++) begin
        if (req_reg[s].valid && lk_hit[s]) begin
          st_mem[lk_idx[s]].hit <= 1'b1; // RULE24
        end
      end
      if (tw_go) begin
        st_mem[tw_idx] <= fhl_stat_t'(twdat_reg[TWDAT_ST_LSB +: 3]);
        shd_mem[0][tw_idx] <= twdat_reg[TWDAT_ST_LSB]; // RULE16
        shd_mem[1][tw_idx] <= twdat_reg[TWDAT_ST_LSB]; // RULE16
      end
    end
  end

  // aging period counter and sweep over every entry
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      age_cnt_reg <= '0;
      sweep_reg <= 1'b0;
      sweep_ix_reg <= '0;
    end else if (sweep_reg) begin
      sweep_ix_reg <= sweep_ix_reg + 1'b1;
      if (sweep_ix_reg == DIDX_W'(DEST_N - 1)) begin
        sweep_reg <= 1'b0;
        sweep_ix_reg <= '0;
      end
    end else if (ctrl_reg[CTRL_AGE_BIT]) begin // RULE11
      if (age_cnt_reg >= 32'(AGE_CYC - 1)) begin
        age_cnt_reg <= '0;
        sweep_reg <= 1'b1;
      end else begin
        age_cnt_reg <= age_cnt_reg + 32'h1;
      end
    end else begin
      age_cnt_reg <= '0;
    end
  end

  // =========================================================
  // destination result
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      da_res_reg <= '0;
    end else begin
      da_res_reg.valid <= req_reg[0].valid;
      da_res_reg.hit <= lk_hit[0];
      da_res_reg.idx <= lk_idx[0];
      da_res_reg.port <= lk_hit[0] ? lk_port[0] : '0; // RULE8
      da_res_reg.drop <= !lk_hit[0] && pdrop_reg[req_reg[0].port]; // RULE13
      da_res_reg.flood <= !lk_hit[0] && !pdrop_reg[req_reg[0].port]; // RULE13
    end
  end

  // source learn decision
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sa_dec_reg <= '0;
      dec_cnt_reg <= '0;
    end else begin
      sa_dec_reg.valid <= req_reg[1].valid && ctrl_reg[CTRL_LEARN_BIT] && plearn_reg[req_reg[1].port]; // RULE12 RULE26
      sa_dec_reg.gid <= req_reg[1].gid; // RULE7
      sa_dec_reg.mac <= req_reg[1].mac; // RULE7
      sa_dec_reg.port <= req_reg[1].port; // RULE7
      sa_dec_reg.idx <= lk_idx[1];
      sa_dec_reg.status <= fhl_stat_t'(ctrl_reg[CTRL_INIT_LSB +: 3]); // RULE14
      if (!lk_hit[1]) begin
        sa_dec_reg.code <= FHL_DEC_LEARN; // RULE20
      end else if (lk_port[1] != req_reg[1].port) begin
        sa_dec_reg.code <= FHL_DEC_MOVE; // RULE10 RULE20
      end else begin
        sa_dec_reg.code <= FHL_DEC_HIT; // RULE20
      end
      if (req_reg[1].valid && ctrl_reg[CTRL_LEARN_BIT] && plearn_reg[req_reg[1].port]) begin
        dec_cnt_reg <= dec_cnt_reg + 16'h1;
      end
    end
  end

  // l3 hashes, used directly as routing table index
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      l3_hash_reg <= '0;
    end else begin
      l3_hash_reg.valid <= l3_reg.valid; // RULE5
      l3_hash_reg.v4 <= fhl_fold({96'h0, l3_reg.vrf, l3_reg.ip4}); // RULE2
      l3_hash_reg.v6 <= fhl_fold({l3_reg.vrf, l3_reg.ip6}); // RULE3
      l3_hash_reg.mpls <= fhl_fold({104'h0, l3_reg.vrf, l3_reg.label, l3_reg.port}); // RULE4
    end
  end

  // =========================================================
  // outputs
  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign da_res_o = da_res_reg;
  assign sa_dec_o = sa_dec_reg;
  assign l3_hash_o = l3_hash_reg;

  // =========================================================
  // checks
  assign mk = {l3_reg.vrf, l3_reg.label, l3_reg.port};

  a_v4_fold: assert property (l3_hash_o.valid |-> l3_hash_o.v4 == $past(l3_reg.ip4[9:0] ^ l3_reg.ip4[19:10] ^ // RULE2
    l3_reg.ip4[29:20] ^ {6'h00, l3_reg.vrf, l3_reg.ip4[31:30]})) else $error("ipv4 hash wrong");
  a_mpls_fold: assert property ($rose(l3_hash_o.valid) || l3_hash_o.valid |-> // RULE4
    l3_hash_o.mpls == $past(mk[9:0] ^ mk[19:10] ^ {4'h0, mk[25:20]})) else $error("mpls hash wrong");
  a_bucket_index: assert property (da_res_o.valid && da_res_o.hit && !da_res_o.idx[HIDX_W] |-> // RULE23
    da_res_o.idx[HASH_W-1:0] == $past(lk_hash[0])) else $error("bucket index not hash");
  a_dest_port: assert property (req_reg[0].valid && lk_hit[0] ##1 da_res_o.valid |-> // RULE8
    da_res_o.hit && da_res_o.port == $past(lk_port[0])) else $error("dest port wrong");
  a_miss_drop: assert property (da_res_o.valid && !da_res_o.hit |-> // RULE13
    da_res_o.drop == $past(pdrop_reg[req_reg[0].port]) && da_res_o.flood != da_res_o.drop) else $error("miss action");
  a_learn_gate: assert property (sa_dec_o.valid |-> $past(ctrl_reg[CTRL_LEARN_BIT]) && // RULE12
    $past(plearn_reg[req_reg[1].port])) else $error("decision while learning off");
  a_move_code: assert property (sa_dec_o.valid && sa_dec_o.code == FHL_DEC_MOVE |-> $past(lk_hit[1]) && // RULE20
    sa_dec_o.port != $past(lk_port[1])) else $error("port move without mismatch");
  a_init_status: assert property (sa_dec_o.valid && sa_dec_o.code == FHL_DEC_LEARN |-> // RULE14
    sa_dec_o.status == $past(ctrl_reg[CTRL_INIT_LSB +: 3])) else $error("learn status wrong");
  a_replica_same: assert property (tw_go |=> port_mem[0][$past(tw_idx)] == port_mem[1][$past(tw_idx)] && // RULE16
    shd_mem[0][$past(tw_idx)] == shd_mem[1][$past(tw_idx)]) else $error("replicas differ");
  a_static_kept: assert property (sweep_reg && st_mem[sweep_ix_reg].valid && st_mem[sweep_ix_reg].stat && !tw_go // RULE9
    |=> st_mem[$past(sweep_ix_reg)].valid) else $error("static entry aged");
endmodule

// ### tb/fhl_ingress_model.sv
/*
  ingress pipeline stand-in: turns bench commands into lookup requests.
  assumes go bits and keys from the bench change just after a rising edge.
*/
`timescale 1ns/100ps
module fhl_ingress_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // bench command: bit0 da, bit1 sa, bit2 l3
  input wire logic [2:0] go_i,
  input wire fhl_pkg::fhl_l2_req_t key_i,
  input wire fhl_pkg::fhl_l3_req_t l3_i,
  // lookup requests
  output fhl_pkg::fhl_l2_req_t da_req_o,
  output fhl_pkg::fhl_l2_req_t sa_req_o,
  output fhl_pkg::fhl_l3_req_t l3_req_o
);
  import fhl_pkg::*;
  // =========================================================
  // one request of each kind per cycle; idle keys scrambled
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      da_req_o <= '0;
      sa_req_o <= '0;
      l3_req_o <= '0;
    end else begin
      da_req_o <= go_i[0] ? {1'b1, key_i[63:0]} : {1'b0, ~da_req_o[63:0]};
      sa_req_o <= go_i[1] ? {1'b1, key_i[63:0]} : {1'b0, ~sa_req_o[63:0]};
      l3_req_o <= go_i[2] ? {1'b1, l3_i[185:0]} : {1'b0, ~l3_req_o[185:0]};
    end
  end
endmodule

// ### tb/fhl_tb_top.sv
/*
  self-checking bench: registers over axi4-lite, l3 hashes, l2 lookups.
  assumes the ingress model drives the lookup ports of the block.
*/
`timescale 1ns/100ps
module fhl_tb_top;
  import fhl_pkg::*;
  // =========================================================
  // signals
  logic clk, rst, awv, wv, br, arv, rr, awr, wrd, bv, arr, rv;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd, rdv;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] go;
  fhl_l2_req_t key, dar, sar;
  fhl_l3_req_t l3k, l3r;
  fhl_da_res_t dao, da_c;
  fhl_sa_dec_t sao, sa_c;
  fhl_l3_hash_t l3o, l3_c;
  int miscompares = 0;
  int tests_run = 0;
  localparam logic [47:0] M = 48'h466162bc84dd;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  fhl_ingress_model u_far (.ref_clk_i(clk), .sys_rst_i(rst), .go_i(go), .key_i(key), .l3_i(l3k),
    .da_req_o(dar), .sa_req_o(sar), .l3_req_o(l3r));
  fhl_top #(.AGE_CYC(20000)) u_dut (.ref_clk_i(clk), .sys_rst_i(rst), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp),
    .da_req_i(dar), .sa_req_i(sar), .l3_req_i(l3r), .da_res_o(dao), .sa_dec_o(sao), .l3_hash_o(l3o));
  // =========================================================
  // helpers
  function automatic logic [9:0] fold(input logic [129:0] k);
    logic [9:0] h;
    h = '0;
    for (int i = 0; i < 13; i++) h = h ^ k[i*10 +: 10];
    return h;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
    resp = bresp;
  endtask
  task rdr(input logic [7:0] a);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rr <= 1'b0;
    resp = rresp;
    rdv = rd;
  endtask
  // one lookup through the model, results captured while they stand
  task lk(input logic [2:0] s, input logic [11:0] g, input logic [47:0] m, input logic [3:0] p);
    @(posedge clk);
    go <= s;
    key <= {1'b0, g, m, p};
    da_c = '0;
    sa_c = '0;
    @(posedge clk);
    go <= 3'h0;
    repeat (5) begin
      @(negedge clk);
      if (dao.valid === 1'b1) da_c = dao;
      if (sao.valid === 1'b1) sa_c = sao;
      if (l3o.valid === 1'b1) l3_c = l3o;
    end
  endtask
  // =========================================================
  // scenarios
  task t_regs;
    rdr(OFS_CTRL);
    chk(rdv, CTRL_RST);
    rdr(OFS_PLEARN);
    chk(rdv, PLEARN_RST);
    rdr(8'h20);
    chk(resp, RESP_SLVERR);
    wr(8'h20, 32'h1);
    chk(resp, RESP_SLVERR);
  endtask
  task t_l3;
    @(posedge clk);
    l3k <= {1'b0, 2'd3, 32'h467762bc, 32'hd8a7da8b, 96'h0, 20'd889984, 4'd8};
    lk(3'h4, 12'h0, 48'h0, 4'h0);
    chk(l3_c.v4, 32'd782);
    chk(l3_c.v6, fold({2'd3, 32'hd8a7da8b, 96'h0}));
    chk(l3_c.mpls, fold({104'h0, 2'd3, 20'd889984, 4'd8}));
  endtask
  task t_l2;
    lk(3'h3, 12'h1de, M, 4'd5);
    chk({sa_c.valid, sa_c.code}, {1'b1, FHL_DEC_LEARN});
    chk(sa_c.status, CTRL_RST[4:2]);
    chk({sa_c.gid, sa_c.port}, {12'h1de, 4'd5});
    chk(sa_c.mac[31:0], M[31:0]);
    chk({da_c.valid, da_c.hit, da_c.drop, da_c.flood}, 4'h9);
    wr(OFS_TWLO, 32'h62bc84dd);
    wr(OFS_TWHI, 32'h01de4661);
    wr(OFS_TWDAT, 32'h15);
    wr(OFS_TWCMD, 32'ha63);
    chk(resp, RESP_OKAY);
    lk(3'h3, 12'h1de, M, 4'd5);
    chk({da_c.hit, da_c.port, da_c.idx}, {1'b1, 4'd5, 13'ha63});
    chk({sa_c.valid, sa_c.code, sa_c.idx}, {1'b1, FHL_DEC_HIT, 13'ha63});
    lk(3'h2, 12'h1de, M, 4'd6);
    chk({sa_c.valid, sa_c.code}, {1'b1, FHL_DEC_MOVE});
    wr(OFS_TWLO, 32'h2);
    wr(OFS_TWHI, 32'h00010000);
    wr(OFS_TWDAT, 32'h19);
    wr(OFS_TWCMD, 32'h1003);
    lk(3'h3, 12'h1, 48'h2, 4'd9);
    chk({da_c.hit, da_c.port, da_c.idx}, {1'b1, 4'd9, 13'h1003});
    chk({sa_c.valid, sa_c.code, sa_c.idx}, {1'b1, FHL_DEC_HIT, 13'h1003});
  endtask
  task t_gate;
    wr(OFS_PLEARN, 32'hffdf);
    wr(OFS_PDROP, 32'h20);
    lk(3'h3, 12'h7, 48'h5, 4'd5);
    chk(sa_c.valid, 1'b0);
    chk({da_c.hit, da_c.drop, da_c.flood}, 3'h2);
    wr(OFS_CTRL, 32'h16);
    lk(3'h2, 12'h7, 48'h5, 4'd6);
    chk(sa_c.valid, 1'b0);
    rdr(OFS_STAT);
    chk(rdv, 32'h0004_0000);
  endtask
  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // =========================================================
  // main sequence and watchdog
  initial begin
    {rst, awv, wv, br, arv, rr, awa, ara, wd, go} = {1'b1, 21'h0, 32'h0, 3'h0};
    key = '0;
    l3k = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_l3;
    t_l2;
    t_gate;
    print_verdict;
  end
  initial begin
    #(3000 * 100);
    miscompares++;
    print_verdict;
  end
endmodule
